// ### ttb_map.vh
`ifndef TTB_MAP_VH
`define TTB_MAP_VH
`define TTB_OFF_CTRL 12'h000
`define TTB_OFF_DELAY 12'h004
`define TTB_OFF_CMD 12'h008
`define TTB_OFF_STATUS 12'h00C
`define TTB_OFF_COUNT 12'h010
`define TTB_OFF_TRIG_IDX 12'h014
`define TTB_OFF_QUAL 12'h100
`define TTB_QUAL_WORDS 80
`define TTB_WORDS_PER_TERM 5
`define TTB_RST_CTRL 32'h0000_0000
`define TTB_RST_DELAY 16'h8000
`define TTB_TRIG_OFF 2'h0
`define TTB_TRIG_IF 2'h1
`define TTB_TRIG_IFNOT 2'h2
`define TTB_BRK_NONE 2'h0
`define TTB_BRK_TRIG 2'h1
`define TTB_BRK_DONE 2'h2
`define TTB_BRK_S2 2'h3
`define TTB_F_TMODE 1:0
`define TTB_F_TSEL 4:2
`define TTB_F_TTHEN 5
`define TTB_F_FIRST 8:6
`define TTB_F_RFILT 9
`define TTB_F_RNEG 10
`define TTB_F_RSEL 13:11
`define TTB_F_BRK 15:14
`define TTB_F_S2SEL 18:16
`define TTB_F_UPPER 21:19
`define TTB_F_RTHEN 22
`define TTB_CMD_BEGIN 0
`define TTB_CMD_END 1
`define TTB_CMD_CLRBRK 2
`define TTB_T_RANGE 31
`define TTB_T_ACTIVE 30
`endif

// ### ttb_trace_trigger.v
// Summary of operation
// - Break setting halts emulation on selected condition.
// - Break on trigger halts when trigger fires.
// - Break on completion halts when delay reaches zero.
// - Break on state bit two condition becoming true.
// - Trigger fires on frame condition first becomes true.
// - Record every frame or only qualifying frames and the trigger frame.
// - Stored frames numbered from capture start; trigger frame index saved.
// - Qualifiers compare masked fields and optional address range, two terms.
// - First THEN second needs second after first.
// - THEN use takes lower three special state bits.
// - Delay decrements per frame recorded after the trigger; zero stops capture.
// - Trace end stops recording; trace begin resumes, but rearms once triggered or finished.
`include "ttb_map.vh"
`timescale 1ns/1ps
`default_nettype none
module ttb_trace_trigger #(
  parameter DW = 16,
  parameter IW = 20
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire emu_start,
  input wire frame_valid,
  input wire [15:0] frame_addr,
  input wire [1:0] cycle_type_field,
  input wire [1:0] frame_state_field,
  input wire [2:0] interrupt_level_field,
  input wire [7:0] frame_data,
  input wire [7:0] port_one_sample,
  input wire [7:0] port_three_sample,
  output reg store_valid,
  output reg [IW-1:0] store_index,
  output reg store_post,
  output reg trace_active,
  output reg emu_break,
  output reg [5:0] special_state_bits
);
  localparam NQ = 8;
  reg [31:0] ctrl_q;
  reg [DW-1:0] delay_q;
  reg [DW-1:0] count_q;
  reg [IW-1:0] idx_q;
  reg [IW-1:0] trig_idx_q;
  reg [31:0] qmem [0:`TTB_QUAL_WORDS-1];
  reg capt_q;
  reg trig_q;
  reg done_q;
  reg seen_q;
  reg tcond_prev_q;
  reg s2_prev_q;
  wire [46:0] frame_vec;
  wire [NQ-1:0] qm;
  wire acc;
  wire wr_en;
  wire rd_req;
  wire qual_hit;
  wire [11:0] qoff;
  wire [6:0] qword;
  wire [2:0] tsel;
  wire [2:0] rsel;
  wire [2:0] fsel;
  wire [2:0] s2sel;
  wire then_hit;
  wire tcond_raw;
  wire tcond;
  wire fire;
  wire rec_raw;
  wire rec_ok;
  wire s2_cond;
  wire s2_rise;
  wire cmd_wr;
  wire start;
  wire stop_cmd;
  wire do_store;
  wire last_post;
  wire brk_on_trig;
  wire brk_on_done;
  wire brk_on_s2;
  wire brk_set;
  reg [31:0] rd_d;
  reg rd_err_d;
  genvar gq;

  assign frame_vec = {port_three_sample, port_one_sample, frame_data,
    interrupt_level_field, frame_state_field, cycle_type_field, frame_addr};

  // Each qualifier ORs two terms; a term is per-bit care plus optional range.
  generate
    for (gq = 0; gq < NQ; gq = gq + 1)
    begin : g_qual
      wire [31:0] a0 = qmem[gq*10];
      wire [31:0] a1 = qmem[gq*10+1];
      wire [31:0] a2 = qmem[gq*10+2];
      wire [31:0] a3 = qmem[gq*10+3];
      wire [31:0] a4 = qmem[gq*10+4];
      wire [31:0] b0 = qmem[gq*10+5];
      wire [31:0] b1 = qmem[gq*10+6];
      wire [31:0] b2 = qmem[gq*10+7];
      wire [31:0] b3 = qmem[gq*10+8];
      wire [31:0] b4 = qmem[gq*10+9];
      wire a_bits = (((frame_vec ^ {a1[14:0], a0}) & {a3[14:0], a2}) == 47'h0);
      wire b_bits = (((frame_vec ^ {b1[14:0], b0}) & {b3[14:0], b2}) == 47'h0);
      wire a_rng = !a1[`TTB_T_RANGE] ||
        (frame_addr >= a4[15:0] && frame_addr <= a4[31:16]);
      wire b_rng = !b1[`TTB_T_RANGE] ||
        (frame_addr >= b4[15:0] && frame_addr <= b4[31:16]);
      assign qm[gq] = (a1[`TTB_T_ACTIVE] && a_bits && a_rng) ||
        (b1[`TTB_T_ACTIVE] && b_bits && b_rng);
    end
  endgenerate

  assign acc = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign rd_req = acc && !pwrite;
  assign qual_hit = (paddr >= `TTB_OFF_QUAL) &&
    (paddr < `TTB_OFF_QUAL + 12'h4 * `TTB_QUAL_WORDS) && (paddr[1:0] == 2'h0);
  // Qualifier words are indexed from the start of their own address window.
  assign qoff = paddr - `TTB_OFF_QUAL;
  assign qword = qoff[8:2];
  assign tsel = ctrl_q[`TTB_F_TSEL];
  assign rsel = ctrl_q[`TTB_F_RSEL];
  assign fsel = ctrl_q[`TTB_F_FIRST];
  assign s2sel = ctrl_q[`TTB_F_S2SEL];

  // The second event only counts on a frame after the first was seen.
  assign then_hit = seen_q && qm[tsel];
  assign tcond_raw = ctrl_q[`TTB_F_TTHEN] ? then_hit : qm[tsel];
  assign tcond = (ctrl_q[`TTB_F_TMODE] == `TTB_TRIG_IF) ? tcond_raw :
    (ctrl_q[`TTB_F_TMODE] == `TTB_TRIG_IFNOT) ? !tcond_raw : 1'b0;
  assign fire = capt_q && frame_valid && !trig_q && tcond && !tcond_prev_q;
  assign rec_raw = ctrl_q[`TTB_F_RTHEN] ? (seen_q && qm[rsel]) : qm[rsel];
  assign rec_ok = !ctrl_q[`TTB_F_RFILT] ||
    (rec_raw ^ ctrl_q[`TTB_F_RNEG]);
  assign do_store = capt_q && frame_valid && (rec_ok || fire);
  assign last_post = do_store && trig_q && (count_q == {{(DW-1){1'b0}}, 1'b1});
  assign s2_cond = qm[s2sel];
  assign s2_rise = frame_valid && s2_cond && !s2_prev_q;
  assign cmd_wr = wr_en && (paddr == `TTB_OFF_CMD);
  assign start = emu_start || (cmd_wr && pwdata[`TTB_CMD_BEGIN]);
  assign stop_cmd = cmd_wr && pwdata[`TTB_CMD_END];
  // Completion uses the live delay count, so a trigger with none left stops at once.
  assign brk_on_trig = (ctrl_q[`TTB_F_BRK] == `TTB_BRK_TRIG) && fire;
  assign brk_on_done = (ctrl_q[`TTB_F_BRK] == `TTB_BRK_DONE) &&
    (last_post || (fire && count_q == {DW{1'b0}}));
  assign brk_on_s2 = (ctrl_q[`TTB_F_BRK] == `TTB_BRK_S2) && s2_rise;
  assign brk_set = brk_on_trig || brk_on_done || brk_on_s2;

  always @*
  begin
    rd_d = 32'h0;
    rd_err_d = 1'b0;
    if (qual_hit)
      rd_d = qmem[qword];
    else
      case (paddr)
        `TTB_OFF_CTRL: rd_d = ctrl_q;
        `TTB_OFF_DELAY: rd_d = {{(32-DW){1'b0}}, delay_q};
        `TTB_OFF_CMD: rd_d = 32'h0;
        `TTB_OFF_STATUS: rd_d = {26'h0, seen_q, emu_break, done_q, trig_q,
          capt_q, store_post};
        `TTB_OFF_COUNT: rd_d = {{(32-DW){1'b0}}, count_q};
        `TTB_OFF_TRIG_IDX: rd_d = {{(32-IW){1'b0}}, trig_idx_q};
        default: rd_err_d = 1'b1;
      endcase
  end

  // One wait state: pready rises in the second access cycle.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= acc;
      pslverr <= acc && rd_err_d;
      prdata <= rd_req ? rd_d : 32'h0;
    end
  end

  // The qualifier memory has no reset and must be written before use.
  always @(posedge pclk)
  begin
    if (wr_en && qual_hit)
      qmem[qword] <= pwdata;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `TTB_RST_CTRL;
      delay_q <= `TTB_RST_DELAY;
    end
    else if (wr_en)
    begin
      if (paddr == `TTB_OFF_CTRL)
        ctrl_q <= pwdata;
      if (paddr == `TTB_OFF_DELAY)
        delay_q <= pwdata[DW-1:0];
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      capt_q <= 1'b0;
      trig_q <= 1'b0;
      done_q <= 1'b0;
      seen_q <= 1'b0;
      tcond_prev_q <= 1'b0;
      s2_prev_q <= 1'b0;
      count_q <= {DW{1'b0}};
      idx_q <= {IW{1'b0}};
      trig_idx_q <= {IW{1'b0}};
    end
    else
    begin
      if (frame_valid)
        s2_prev_q <= s2_cond;
      if (start && !trig_q && !done_q && capt_q == 1'b0 && emu_start == 1'b0)
      begin
        capt_q <= 1'b1;
      end
      else if (start)
      begin
        capt_q <= 1'b1;
        trig_q <= 1'b0;
        done_q <= 1'b0;
        seen_q <= 1'b0;
        tcond_prev_q <= 1'b0;
        count_q <= delay_q;
        idx_q <= {IW{1'b0}};
        trig_idx_q <= {IW{1'b0}};
      end
      else if (stop_cmd)
        capt_q <= 1'b0;
      else if (capt_q && frame_valid)
      begin
        tcond_prev_q <= tcond;
        if (qm[fsel])
          seen_q <= 1'b1;
        if (do_store)
          idx_q <= idx_q + {{(IW-1){1'b0}}, 1'b1};
        if (fire)
        begin
          trig_q <= 1'b1;
          trig_idx_q <= idx_q;
          if (count_q == {DW{1'b0}})
          begin
            capt_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        else if (do_store && trig_q)
        begin
          count_q <= count_q - {{(DW-1){1'b0}}, 1'b1};
          if (last_post)
          begin
            capt_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
      end
    end
  end

  // A trace begin after a trace end resumes without rearming; a begin once
  // the trace has triggered or finished, or an emulation start, rearms.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      store_valid <= 1'b0;
      store_index <= {IW{1'b0}};
      store_post <= 1'b0;
      trace_active <= 1'b0;
      emu_break <= 1'b0;
      special_state_bits <= 6'h0;
    end
    else
    begin
      store_valid <= do_store && !start && !stop_cmd;
      store_index <= idx_q;
      store_post <= start ? 1'b0 : (trig_q || (fire && !stop_cmd));
      trace_active <= capt_q;
      if (brk_set && capt_q)
        emu_break <= 1'b1;
      else if (cmd_wr && pwdata[`TTB_CMD_CLRBRK])
        emu_break <= 1'b0;
      special_state_bits[5:3] <= ctrl_q[`TTB_F_UPPER];
      if (ctrl_q[`TTB_F_TTHEN] || ctrl_q[`TTB_F_RTHEN])
        special_state_bits[2:0] <= {1'b0, then_hit, seen_q};
      else
        special_state_bits[2:0] <= {s2_cond, 2'h0};
    end
  end
endmodule
`default_nettype wire

// ### ttb_trace_trigger_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ttb_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire emu_start,
  input wire frame_valid,
  input wire store_valid,
  input wire store_post,
  input wire trace_active,
  input wire emu_break
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("late pready");
  chk_apb_pulse: assert property (pready |=> !pready)
    else $error("long pready");
  chk_err_pair: assert property (pslverr |-> pready)
    else $error("lone pslverr");
  chk_brk_hold:
    assert property (emu_break && !emu_start && !(pready && paddr == 12'h008) |=> emu_break)
    else $error("break dropped");
  chk_brk_cause:
    assert property ($rose(emu_break) |-> trace_active) else $error("idle break");
  chk_idle_drop:
    assert property (frame_valid ##1 !trace_active |-> !store_valid)
    else $error("idle store");
  chk_store_src:
    assert property (store_valid |-> $past(frame_valid)) else $error("store no frame");
  chk_post_rise:
    assert property ($rose(store_post) |-> store_valid) else $error("post no store");
  cover property (store_valid && store_post);
  cover property ($rose(emu_break));
  cover property (pslverr);
endmodule
bind ttb_trace_trigger ttb_chk i_chk (.pclk, .presetn, .psel, .penable, .paddr, .pready,
  .pslverr, .emu_start, .frame_valid, .store_valid, .store_post, .trace_active, .emu_break);
`default_nettype wire

// ### ttb_frame_src.sv
`timescale 1ns/1ps
`default_nettype none
module ttb_frame_src (
  input wire logic pclk,
  input wire logic req,
  input wire logic [2:0] lvl,
  input wire logic [31:0] rnd,
  output logic frame_valid,
  output logic [46:0] fv
);
  // Between frames the bus inverts every cycle, starting with the inverse of the last frame.
  always @(posedge pclk)
  begin
    frame_valid <= req;
    fv <= req ? {rnd[23:0], lvl, rnd[19:0]} : ~fv;
  end
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, emu_start, req, frame_valid, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, lf, r, t;
  logic [2:0] lvl;
  logic [46:0] fv;
  logic [20:0] exp_q[$];
  wire [31:0] prdata;
  wire pready, pslverr, store_valid, store_post, trace_active, emu_break;
  wire [19:0] store_index;
  wire [5:0] ssb;
  int err_count, comparisons, idx, n;
  ttb_frame_src i_src (.pclk, .req, .lvl, .rnd(lf), .frame_valid, .fv);
  ttb_trace_trigger i_ttb_trace_trigger (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .emu_start, .frame_valid, .frame_addr(fv[15:0]),
    .cycle_type_field(fv[17:16]), .frame_state_field(fv[19:18]),
    .interrupt_level_field(fv[22:20]), .frame_data(fv[30:23]),
    .port_one_sample(fv[38:31]), .port_three_sample(fv[46:39]), .store_valid,
    .store_index, .store_post, .trace_active, .emu_break, .special_state_bits(ssb));
  initial
  begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  function logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  task stop_test();
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [32:0] g, input logic [32:0] x);
    comparisons++;
    if (g !== x)
    begin
      err_count++;
      $display("unexpected %0t got %h want %h", $time, g, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    if (n >= 20)
    begin
      chk(0, 1);
      stop_test();
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(0, a, 32'h0);
    chk({e, r}, {xe, x});
  endtask
  task start();
    emu_start <= 1;
    @(posedge pclk);
    emu_start <= 0;
    idx = 0;
  endtask
  task fr(input logic [2:0] l, input logic s, input logic p);
    req <= 1;
    lvl <= l;
    t = rnd();
    if (s)
    begin
      exp_q.push_back({p, idx[19:0]});
      idx++;
    end
    @(posedge pclk);
  endtask
  task idle();
    req <= 0;
    repeat (4) @(posedge pclk);
  endtask
  always @(posedge pclk)
    if (store_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(1, 0);
      else
        chk({store_post, store_index}, exp_q.pop_front());
    end
  initial
  begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 12'h000;
    pwdata = 32'h0;
    emu_start = 0;
    req = 0;
    lvl = 3'h0;
    lf = 32'h0001_7DFA;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(12'h000, 32'h0, 0);
    rd(12'h004, 32'h8000, 0);
    rd(12'h018, 32'h0, 1);
    apb(1, 12'h104, 32'h4000_0000);
    apb(1, 12'h108, 32'h0070_0000);
    apb(1, 12'h10C, 32'h0);
    apb(1, 12'h100, 32'h0);
    apb(1, 12'h118, 32'h0);
    apb(1, 12'h000, 32'h200);
    start();
    repeat (16)
    begin
      t = rnd();
      fr(t[2:0], t[2:0] == 3'h0, 0);
    end
    idle();
    apb(1, 12'h008, 32'h2);
    repeat (3) fr(3'h0, 0, 0);
    idle();
    apb(1, 12'h008, 32'h1);
    repeat (3) fr(3'h0, 1, 0);
    idle();
    apb(1, 12'h000, 32'h4002);
    apb(1, 12'h004, 32'h3);
    start();
    fr(0, 1, 0);
    fr(0, 1, 0);
    fr(1, 1, 1);
    fr(1, 1, 1);
    fr(0, 1, 1);
    fr(1, 1, 1);
    fr(0, 0, 0);
    idle();
    chk(emu_break, 1);
    chk(trace_active, 0);
    rd(12'h014, 32'h2, 0);
    rd(12'h010, 32'h0, 0);
    apb(1, 12'h008, 32'h4);
    chk(emu_break, 0);
    apb(1, 12'h000, 32'h8001);
    apb(1, 12'h004, 32'h2);
    start();
    fr(1, 1, 0);
    fr(0, 1, 1);
    fr(1, 1, 1);
    idle();
    chk(emu_break, 0);
    fr(0, 1, 1);
    fr(0, 0, 0);
    idle();
    chk(emu_break, 1);
    apb(1, 12'h008, 32'h4);
    apb(1, 12'h000, 32'hC000);
    start();
    fr(1, 1, 0);
    fr(1, 1, 0);
    idle();
    chk(emu_break, 0);
    fr(0, 1, 0);
    idle();
    chk(emu_break, 1);
    chk({ssb[5:3], ssb[1:0]}, 5'h0);
    apb(1, 12'h008, 32'h4);
    apb(1, 12'h128, 32'h0020_0000);
    apb(1, 12'h12C, 32'h4000_0000);
    apb(1, 12'h130, 32'h0070_0000);
    apb(1, 12'h134, 32'h0);
    apb(1, 12'h140, 32'h0);
    apb(1, 12'h000, 32'h0028_0E61);
    apb(1, 12'h004, 32'h1);
    start();
    fr(0, 1, 0);
    fr(2, 0, 0);
    fr(0, 1, 1);
    fr(0, 1, 1);
    fr(0, 0, 0);
    idle();
    rd(12'h014, 32'h1, 0);
    rd(12'h00C, 32'h2D, 0);
    chk({ssb[5:3], ssb[2], ssb[0]}, {3'h5, 1'b0, 1'b1});
    chk(exp_q.size(), 0);
    stop_test();
  end
endmodule
`default_nettype wire
